/* common/baec_pkg.sv */
// Package of constants and carrier types for the bus activity event counter.
package baec_pkg;

  // ==========================================================================
  // Event codes
  localparam logic [7:0] EVT_BUS_NOT_READY_DRIVEN = 8'h61;
  localparam logic [7:0] EVT_DATA_READY_CYCLES = 8'h62;
  localparam logic [7:0] EVT_BUS_LOCK_CYCLES = 8'h63;
  localparam logic [7:0] EVT_DATA_RECEIVE_CYCLES = 8'h64;
  localparam logic [7:0] EVT_BURST_READ_TRANS = 8'h65;
  localparam logic [7:0] EVT_READ_FOR_OWNERSHIP_TRANS = 8'h66;

  // ==========================================================================
  // Widths, limits and reset values
  localparam int COUNT_WIDTH = 40;
  localparam int OUTSTANDING_WIDTH = 4;
  localparam logic [3:0] OUTSTANDING_MAX = 4'hC;
  localparam logic [3:0] NOT_READY_MARGIN = 4'h2;
  localparam logic [7:0] EVENT_SEL_RESET = 8'h00;

  // ==========================================================================
  // Transaction kinds issued by this agent.
  typedef enum logic [2:0] {
    BAEC_TK_NONE,
    BAEC_TK_BURST_READ,
    BAEC_TK_READ_FOR_OWNERSHIP,
    BAEC_TK_WRITEBACK,
    BAEC_TK_PARTIAL_WRITE,
    BAEC_TK_OTHER
  } baec_trans_kind_e;

  // Source of a burst read; all count toward the burst read event.
  typedef enum logic [1:0] {
    BAEC_SRC_L1_DATA_MISS,
    BAEC_SRC_L1_PREFETCH,
    BAEC_SRC_L2_PREFETCH,
    BAEC_SRC_INSTRUCTION_FETCH_UNIT
  } baec_read_src_e;

  // Bus-side observations for one bus cycle.
  typedef struct packed {
    logic busNotReady;      // Any agent holds the bus not ready.
    logic dataReadyStrobe;  // Data ready asserted on the bus.
    logic busLock;          // Lock asserted on the bus.
    logic dataReceive;      // This agent is receiving data.
  } baec_bus_obs_s;

  // A transaction completion reported by the bus interface.
  typedef struct packed {
    logic valid;
    baec_trans_kind_e kind;
    baec_read_src_e readSrc;
    logic fromLockedOp;
  } baec_trans_done_s;

endpackage

/* hdl/baec_bus_activity_counter.sv */
// Bus activity event counter with local bus-not-ready generation.
`timescale 1ns/10ps
// ============================================================================
// Notes on behaviour
// - Code 61H counts our bus-not-ready assertions.
// - Drive not-ready near outstanding transaction maximum.
// - No new transaction while any not-ready.
// - Code 62H counts data-ready bus cycles.
// - Data-ready covers all our write data.
// - Code 63H counts bus-lock cycles.
// - Assert bus lock for locked accesses.
// - Code 64H counts data-receive cycles.
// - Code 65H counts burst read transactions.
// - Burst read count excludes read-for-ownership.
// - Code 66H counts read-for-ownership transactions.
// - Read-for-ownership includes locked-operation ones.
// - Bus events are thread independent.
module baec_bus_activity_counter #(
  parameter int COUNT_W = baec_pkg::COUNT_WIDTH,
  parameter int OUT_W = baec_pkg::OUTSTANDING_WIDTH
) (
  input wire logic clk,                                  // Bus clock, 125 MHz.
  input wire logic arst_n,                               // Asynchronous reset, active low.
  input wire logic busEnable,                            // One-cycle bus clock enable.
  input wire logic countEnable,                          // Counting allowed.
  input wire logic [7:0] eventSelect,                    // Selected event code.
  input wire logic anyThreadQualifier,                   // Any-thread qualifier, no effect here.
  input wire logic [1:0] threadId,                       // Requesting logical processor, ignored.
  input wire baec_pkg::baec_bus_obs_s busObs,            // Bus-wide signal levels.
  input wire logic otherNotReady,                        // Other agents drive not-ready.
  input wire logic txnIssueReq,                          // Core wants to start a transaction.
  input wire logic txnDataDone,                          // A data or snoop transaction retired.
  input wire logic snoopStart,                           // A snoop transaction begins.
  input wire logic writeDataDrive,                       // We drive write data this bus cycle.
  input wire logic lockedAccess,                         // Locked access in progress.
  input wire baec_pkg::baec_trans_done_s transDone,      // Transaction completion report.
  output logic busNotReadyOut,                           // Our bus-not-ready drive.
  output logic dataReadyStrobeOut,                       // Our data-ready drive.
  output logic busLockOut,                               // Our bus lock drive.
  output logic txnIssueGrant,                            // Transaction may be issued now.
  output logic [COUNT_W-1:0] eventCount,                 // Accumulated event count.
  output logic unsupportedEvent                          // Selected code not supported.
);
  import baec_pkg::*;

  // ==========================================================================
  // Helpers
  function automatic logic isSupported(input logic [7:0] code);
    isSupported = (code >= EVT_BUS_NOT_READY_DRIVEN) && (code <= EVT_READ_FOR_OWNERSHIP_TRANS);
  endfunction

  // ==========================================================================
  // Outstanding transactions and bus-not-ready drive
  logic [OUT_W-1:0] outstanding_q, outstanding_d;
  logic notReady_q, notReady_d;
  logic notReadyRise;

  assign txnIssueGrant = txnIssueReq && !notReady_q && !otherNotReady;

  always_comb begin
    outstanding_d = outstanding_q;
    if ((txnIssueGrant || snoopStart) && !txnDataDone) begin
      outstanding_d = outstanding_q + OUT_W'(1);
    end else if (!(txnIssueGrant || snoopStart) && txnDataDone && outstanding_q != '0) begin
      outstanding_d = outstanding_q - OUT_W'(1);
    end
    // Asserting a margin early leaves room for requests already in flight.
    notReady_d = (outstanding_d >= OUT_W'(OUTSTANDING_MAX - NOT_READY_MARGIN));
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      outstanding_q <= '0;
      notReady_q <= 1'b0;
    end else begin
      outstanding_q <= outstanding_d;
      notReady_q <= notReady_d;
    end
  end

  assign busNotReadyOut = notReady_q;

  // ==========================================================================
  // Data-ready and lock drives, registered for clean outputs
  logic data_ready_strobe_q, data_ready_strobe_d, lock_q, lock_d, nrPrev_q, nrPrev_d;

  always_comb begin
    data_ready_strobe_d = writeDataDrive;
    lock_d = lockedAccess;
    nrPrev_d = notReady_q;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      data_ready_strobe_q <= 1'b0;
      lock_q <= 1'b0;
      nrPrev_q <= 1'b0;
    end else begin
      data_ready_strobe_q <= data_ready_strobe_d;
      lock_q <= lock_d;
      nrPrev_q <= nrPrev_d;
    end
  end

  assign dataReadyStrobeOut = data_ready_strobe_q;
  assign busLockOut = lock_q;
  assign notReadyRise = notReady_q && !nrPrev_q;

  // ==========================================================================
  // Event counter
  // Thread identity and the any-thread qualifier are deliberately unused:
  // bus events are shared, so a per-thread split would double count.
  logic [COUNT_W-1:0] count_q, count_d;
  logic cycleHit, transHit, inc;
  logic pendRise_q, pendRise_d;

  always_comb begin
    // A not-ready rise between bus enables is held until the next one.
    pendRise_d = pendRise_q;
    if (busEnable) begin
      pendRise_d = 1'b0;
    end
    // A rise that meets a bus enable is counted at once, so holding it as
    // well would count the same assertion a second time.
    if (notReadyRise && !busEnable) begin
      pendRise_d = 1'b1;
    end
    cycleHit = 1'b0;
    transHit = 1'b0;
    unique case (eventSelect)
      EVT_BUS_NOT_READY_DRIVEN: cycleHit = pendRise_q || notReadyRise;
      EVT_DATA_READY_CYCLES: cycleHit = busObs.dataReadyStrobe || data_ready_strobe_q;
      EVT_BUS_LOCK_CYCLES: cycleHit = busObs.busLock || lock_q;
      EVT_DATA_RECEIVE_CYCLES: cycleHit = busObs.dataReceive;
      EVT_BURST_READ_TRANS: transHit = transDone.valid && transDone.kind == BAEC_TK_BURST_READ;
      EVT_READ_FOR_OWNERSHIP_TRANS: transHit = transDone.valid && transDone.kind == BAEC_TK_READ_FOR_OWNERSHIP;
      default: ;
    endcase
    inc = countEnable && isSupported(eventSelect) && ((busEnable && cycleHit) || transHit);
    count_d = inc ? count_q + COUNT_W'(1) : count_q;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_q <= '0;
      pendRise_q <= 1'b0;
    end else begin
      count_q <= count_d;
      pendRise_q <= pendRise_d;
    end
  end

  assign eventCount = count_q;
  assign unsupportedEvent = !isSupported(eventSelect);

endmodule // baec_bus_activity_counter

/* verif/baec_asserts.sv */
// Port checker for the bus activity event counter.
`timescale 1ns/10ps
module baec_asserts
  import baec_pkg::*;
#(parameter int COUNT_W = COUNT_WIDTH) (
  input wire logic clk, arst_n, busEnable, countEnable, // Clock, reset, enables.
  input wire logic [7:0] eventSelect, // Event code.
  input wire baec_bus_obs_s busObs, // Bus levels.
  input wire logic otherNotReady, txnIssueReq, writeDataDrive, lockedAccess, // Requests.
  input wire baec_trans_done_s transDone, // Completion.
  input wire logic busNotReadyOut, dataReadyStrobeOut, busLockOut, txnIssueGrant, unsupportedEvent, // Drives.
  input wire logic [COUNT_W-1:0] eventCount // Count.
);
  // ==========================================================================
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  grant_gate_a: assert property (txnIssueGrant == (txnIssueReq && !busNotReadyOut && !otherNotReady))
    else $error("bad grant");
  data_drive_a: assert property (writeDataDrive |=> dataReadyStrobeOut) else $error("no data ready");
  lock_drive_a: assert property (lockedAccess |=> busLockOut) else $error("no lock");
  code_check_a: assert property (unsupportedEvent == !(eventSelect inside {[8'h61:8'h66]}))
    else $error("bad code flag");
  one_step_a: assert property (eventCount - $past(eventCount) <= 1) else $error("count jump");
  data_ready_strobe_count_a: assert property (countEnable && busEnable && eventSelect == 8'h62 && busObs.dataReadyStrobe
    |=> eventCount == $past(eventCount) + 1'b1) else $error("cycle missed");
  own_count_a: assert property (countEnable && eventSelect == 8'h66 && transDone.valid
    && transDone.kind == BAEC_TK_READ_FOR_OWNERSHIP |=> eventCount == $past(eventCount) + 1'b1) else $error("missed");
  burst_only_a: assert property (countEnable && eventSelect == 8'h65
    && !(transDone.valid && transDone.kind == BAEC_TK_BURST_READ) |=> $stable(eventCount)) else $error("extra");
endmodule // baec_asserts

bind baec_bus_activity_counter baec_asserts #(.COUNT_W(COUNT_W)) i_baec_asserts(.*);

/* verif/baec_bus_agents.sv */
// Model of the other agents on the shared bus.
`timescale 1ns/10ps
module baec_bus_agents
  import baec_pkg::*;
(
  input wire logic clk, arst_n, // Clock and reset.
  input wire logic [2:0] noise, // Random activity.
  input wire logic ourNotReady, ourDataReady, ourLock, // Device drives.
  output logic otherNotReady, // Others hold off.
  output baec_bus_obs_s busObs // Wired-or levels.
);
  logic othDrdy, othRecv;
  // The others never issue, so they cannot start one while any not-ready stands.
  always @(posedge clk or negedge arst_n)
    if (!arst_n) {otherNotReady, othDrdy, othRecv} <= 3'h0;
    else {otherNotReady, othDrdy, othRecv} <= noise;
  assign busObs = '{ourNotReady | otherNotReady, ourDataReady | othDrdy, ourLock, othRecv};
endmodule // baec_bus_agents

/* verif/testbench.sv */
// Self-checking bench for the bus activity event counter.
`timescale 1ns/10ps
module testbench;
  import baec_pkg::*;
  logic clk = 0, arst_n = 0, busEnable = 0, countEnable = 0, anyThreadQualifier = 0, txnIssueReq = 0;
  logic txnDataDone = 0, snoopStart = 0, writeDataDrive = 0, lockedAccess = 0, chk = 0, wddQ, lockQ;
  logic busNotReadyOut, dataReadyStrobeOut, busLockOut, txnIssueGrant, unsupportedEvent, otherNotReady;
  logic [1:0] threadId = 0;
  logic [2:0] noise = 0;
  logic [7:0] eventSelect = 8'h62;
  logic [7:0] codes [7] = '{8'h62, 8'h63, 8'h64, 8'h65, 8'h66, 8'h60, 8'h67};
  logic [39:0] eventCount, expCount;
  baec_bus_obs_s busObs;
  baec_trans_done_s transDone = '0;
  int num_errors = 0, cmp_count = 0;
  always #4 clk = ~clk;
  baec_bus_activity_counter i_baec_bus_activity_counter(.*);
  baec_bus_agents i_baec_bus_agents(.clk(clk), .arst_n(arst_n), .noise(noise), .ourNotReady(busNotReadyOut),
    .ourDataReady(dataReadyStrobeOut), .ourLock(busLockOut), .otherNotReady(otherNotReady), .busObs(busObs));
  // ==========================================================================
  // Reference count; thread inputs are left out on purpose.
  always @(posedge clk) begin
    wddQ <= writeDataDrive & arst_n;
    lockQ <= lockedAccess & arst_n;
    if (!arst_n) expCount <= '0;
    else if (countEnable) case (eventSelect)
      8'h62: expCount <= expCount + (busEnable & (busObs.dataReadyStrobe | wddQ));
      8'h63: expCount <= expCount + (busEnable & (busObs.busLock | lockQ));
      8'h64: expCount <= expCount + (busEnable & busObs.dataReceive);
      8'h65: expCount <= expCount + (transDone.valid && transDone.kind == BAEC_TK_BURST_READ);
      8'h66: expCount <= expCount + (transDone.valid && transDone.kind == BAEC_TK_READ_FOR_OWNERSHIP);
      default: ;
    endcase
  end
  task automatic check(input string what, input logic [39:0] expVal, seen);
    cmp_count++;
    if (expVal !== seen) begin
      num_errors++;
      $display("ERROR %s expected %0h seen %0h", what, expVal, seen);
    end
  endtask
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(negedge clk) if (chk) check("eventCount", expCount, eventCount);
  // ==========================================================================
  // Sequence
  initial begin
    void'($urandom(32'h71ED5B56));
    repeat (4) @(posedge clk);
    #1 arst_n = 1;
    chk = 1;
    foreach (codes[i]) begin
      eventSelect = codes[i];
      repeat (300) begin
        @(posedge clk);
        #1 {busEnable, countEnable, writeDataDrive, lockedAccess, anyThreadQualifier, threadId, noise} = 10'($urandom);
        transDone = '{1'($urandom), baec_trans_kind_e'($urandom_range(5)), baec_read_src_e'($urandom_range(3)), 1'($urandom)};
      end
      check("unsupportedEvent", !(codes[i] inside {[8'h61:8'h66]}), unsupportedEvent);
    end
    // Second reset clears the outstanding count before the not-ready walk.
    chk = 0;
    arst_n = 0;
    {busEnable, countEnable, writeDataDrive, lockedAccess, noise} = '0;
    transDone = '0;
    eventSelect = EVT_BUS_NOT_READY_DRIVEN;
    @(posedge clk);
    #1 arst_n = 1;
    {busEnable, countEnable, txnIssueReq} = 3'h7;
    repeat (9) @(posedge clk);
    #1 check("busNotReadyOut", 0, busNotReadyOut);
    {txnIssueReq, snoopStart} = 2'h1;
    @(posedge clk);
    #1 {txnIssueReq, snoopStart} = 2'h2;
    #1 check("busNotReadyOut", 1, busNotReadyOut);
    check("txnIssueGrant", 0, txnIssueGrant);
    @(posedge clk);
    #1 {txnIssueReq, txnDataDone} = 2'h1;
    @(posedge clk);
    #1 {txnIssueReq, txnDataDone} = 2'h2;
    @(posedge clk);
    #1 txnIssueReq = 0;
    repeat (4) @(posedge clk);
    #1 check("eventCount", 2, eventCount);
    give_verdict();
  end
endmodule // testbench
